// ==== hw/fld_burst_cnt.sv ====
// Counts events inside one window and flags when a threshold is reached.
// Assumes event and window inputs are already in the i_clk domain.
`timescale 1ns/1ps
module fld_burst_cnt
    import fld_pkg::*;
#(
    parameter int THRESH = FLD_RXER_THRESH
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Event bundle
    fld_evt_if.cnt    evt
);
    localparam logic [FLD_CNT_W-1:0] THR = FLD_CNT_W'(THRESH);

    logic [FLD_CNT_W-1:0] cnt_reg;
    logic [FLD_CNT_W-1:0] cnt_next;
    logic                 hit;

    // Count saturates at the threshold, so the width never overflows
    assign hit      = evt.enable && evt.event_in && (cnt_reg == THR - 1'b1);
    assign cnt_next = (evt.window_start || !evt.enable) ? '0 :
                      (evt.event_in && cnt_reg != THR) ?
                      cnt_reg + 1'b1 : cnt_reg;
    assign evt.trip = hit;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    AST_CNT_RESTART: assert property (@(posedge i_clk) disable iff (!i_resetn)
        evt.window_start |=> cnt_reg == '0)
        else $error("counter not cleared at window start");
endmodule

// ==== hw/fld_evt_if.sv ====
// Event bundle between the top and the burst counter.
// Assumes both ends share i_clk.
`timescale 1ns/1ps
interface fld_evt_if;
    logic window_start;
    logic event_in;
    logic enable;
    logic trip;
    modport ctrl (output window_start, output event_in, output enable,
                  input trip);
    modport cnt  (input window_start, input event_in, input enable,
                  output trip);
endinterface

// ==== hw/fld_pkg.sv ====
// Fast link-down control: register map, field positions, timing constants.
// Assumes a 200 MHz core clock and a 32-bit APB register bus.
package fld_pkg;

    // ************************************************************
    // Register map (word per register, byte address = index * 4)
    // ************************************************************
    localparam logic [11:0] FLD_CTRL3_IDX      = 12'h00b;
    localparam logic [11:0] FLD_STATUS_IDX     = 12'h00f;
    localparam logic [11:0] FLD_IRQ_STAT_IDX   = 12'h040;
    localparam logic [11:0] FLD_IRQ_MASK_IDX   = 12'h041;
    localparam logic [11:0] FLD_ADDR_CTRL3     = 12'h02c;
    localparam logic [11:0] FLD_ADDR_STATUS    = 12'h03c;
    localparam logic [11:0] FLD_ADDR_IRQ_STAT  = 12'h100;
    localparam logic [11:0] FLD_ADDR_IRQ_MASK  = 12'h104;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int          FLD_B_EQ_ERR_BYP   = 12;
    localparam int          FLD_B_DESCR_DROP   = 10;
    localparam int          FLD_B_COEF_BYP     = 9;
    localparam int          FLD_B_POL_SWAP     = 6;
    localparam int          FLD_B_PAIR_SWAP    = 5;
    localparam int          FLD_B_RXER_DROP    = 3;
    localparam int          FLD_B_CODE_DROP    = 2;
    localparam int          FLD_B_SNR_DROP     = 1;
    localparam int          FLD_B_ENERGY_DROP  = 0;
    localparam logic [15:0] FLD_CTRL3_RESET    = 16'h1000;
    localparam logic [15:0] FLD_CTRL3_WMASK    = 16'hf7ff;

    // ************************************************************
    // Cause indices (status field sits at bits 8:4)
    // ************************************************************
    localparam int          FLD_NCAUSE         = 5;
    localparam int          FLD_C_ENERGY       = 0;
    localparam int          FLD_C_SNR          = 1;
    localparam int          FLD_C_CODE         = 2;
    localparam int          FLD_C_RXER         = 3;
    localparam int          FLD_C_DESCR        = 4;
    localparam int          FLD_STATUS_LSB     = 4;

    // ************************************************************
    // Timing and thresholds
    // ************************************************************
    localparam int          FLD_CLK_MHZ        = 200;
    localparam int          FLD_WINDOW_US      = 10;
    localparam int          FLD_WINDOW_CYC     = FLD_WINDOW_US * FLD_CLK_MHZ;
    localparam int          FLD_RXER_THRESH    = 32;
    localparam int          FLD_CODE_THRESH    = 20;
    localparam int          FLD_SNR_THRESH     = 20;
    localparam int          FLD_CNT_W          = 6;
    localparam int          FLD_TMR_W          = 12;

endpackage

// ==== hw/fld_top.sv ====
// Third link control register with the fast link-down monitor.
// Assumes PHY status inputs are asynchronous and APB runs on i_clk.
`timescale 1ns/1ps
module fld_top
    import fld_pkg::*;
#(
    parameter int WINDOW_CYC = FLD_WINDOW_CYC
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // PHY condition inputs (asynchronous)
    input  wire logic        i_descr_loss,
    input  wire logic        i_rx_err,
    input  wire logic        i_code_viol,
    input  wire logic        i_snr_cross,
    input  wire logic        i_energy_loss,
    input  wire logic        i_eq_err,
    // PHY controls
    output logic             o_link_drop,
    output logic             o_eq_err_use,
    output logic             o_coef0_bypass,
    output logic             o_pol_invert,
    output logic             o_pair_swap,
    output logic             o_port_mirror,
    output logic             o_irq
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int NIN = 6;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    assign raw = {i_eq_err, i_descr_loss, i_rx_err, i_code_viol,
                  i_snr_cross, i_energy_loss};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // Event inputs are level-sampled; edge detection turns them into counts
    logic [NIN-1:0] prev_reg;
    logic [NIN-1:0] rise;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync2_reg;
        end
    end
    assign rise = sync2_reg & ~prev_reg;

    // ************************************************************
    // Control register and APB decode
    // ************************************************************
    logic [15:0] ctrl3_reg;
    logic [15:0] ctrl3_next;
    logic [FLD_NCAUSE-1:0] status_reg;
    logic [FLD_NCAUSE-1:0] status_next;
    logic [FLD_NCAUSE-1:0] irq_stat_reg;
    logic [FLD_NCAUSE-1:0] irq_stat_next;
    logic [FLD_NCAUSE-1:0] irq_mask_reg;
    logic [FLD_NCAUSE-1:0] irq_mask_next;

    wire acc       = i_psel && i_penable;
    wire wr        = acc && i_pwrite;
    wire rd        = acc && !i_pwrite;
    wire sel_ctrl  = (i_paddr == FLD_ADDR_CTRL3);
    wire sel_stat  = (i_paddr == FLD_ADDR_STATUS);
    wire sel_istat = (i_paddr == FLD_ADDR_IRQ_STAT);
    wire sel_imask = (i_paddr == FLD_ADDR_IRQ_MASK);
    wire mapped    = sel_ctrl || sel_stat || sel_istat || sel_imask;

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata = {16'h0000, ctrl3_reg};
        end else if (sel_stat) begin
            rdata = {23'h000000, status_reg, 4'h0};
        end else if (sel_istat) begin
            rdata = {27'h0000000, irq_stat_reg};
        end else if (sel_imask) begin
            rdata = {27'h0000000, irq_mask_reg};
        end
    end

    // Bit 11 has no function here and stays zero
    assign ctrl3_next = (wr && sel_ctrl) ?
                        (i_pwdata[15:0] & FLD_CTRL3_WMASK) : ctrl3_reg;

    // ************************************************************
    // Window timer
    // ************************************************************
    logic [FLD_TMR_W-1:0] tmr_reg;
    logic [FLD_TMR_W-1:0] tmr_next;
    wire  win_start = (tmr_reg == FLD_TMR_W'(WINDOW_CYC - 1));
    assign tmr_next = win_start ? '0 : tmr_reg + 1'b1;

    // ************************************************************
    // Burst counters
    // ************************************************************
    fld_evt_if rxer_if ();
    fld_evt_if code_if ();
    fld_evt_if snr_if ();

    assign rxer_if.window_start = win_start;
    assign rxer_if.event_in     = rise[FLD_C_RXER];
    assign rxer_if.enable       = ctrl3_reg[FLD_B_RXER_DROP];
    assign code_if.window_start = win_start;
    assign code_if.event_in     = rise[FLD_C_CODE];
    assign code_if.enable       = ctrl3_reg[FLD_B_CODE_DROP];
    assign snr_if.window_start  = win_start;
    assign snr_if.event_in      = rise[FLD_C_SNR];
    assign snr_if.enable        = ctrl3_reg[FLD_B_SNR_DROP];

    fld_burst_cnt #(.THRESH(FLD_RXER_THRESH)) u_rxer (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .evt      (rxer_if.cnt)
    );
    fld_burst_cnt #(.THRESH(FLD_CODE_THRESH)) u_code (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .evt      (code_if.cnt)
    );
    fld_burst_cnt #(.THRESH(FLD_SNR_THRESH)) u_snr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .evt      (snr_if.cnt)
    );

    // ************************************************************
    // Drop decision and status
    // ************************************************************
    logic [FLD_NCAUSE-1:0] cause;
    assign cause[FLD_C_DESCR]  = ctrl3_reg[FLD_B_DESCR_DROP] &&
                                 sync2_reg[FLD_C_DESCR];
    assign cause[FLD_C_RXER]   = rxer_if.trip;
    assign cause[FLD_C_CODE]   = code_if.trip;
    assign cause[FLD_C_SNR]    = snr_if.trip;
    assign cause[FLD_C_ENERGY] = ctrl3_reg[FLD_B_ENERGY_DROP] &&
                                 sync2_reg[FLD_C_ENERGY];
    wire drop_any = |cause;

    // Latched-high; status clears on read, irq status on a write of ones; a new cause in the clearing cycle wins
    assign status_next = ((rd && sel_stat) ? '0 : status_reg)
                         | cause;
    assign irq_stat_next = ((wr && sel_istat) ?
                            (irq_stat_reg & ~i_pwdata[FLD_NCAUSE-1:0]) :
                            irq_stat_reg) | cause;
    assign irq_mask_next = (wr && sel_imask) ?
                           i_pwdata[FLD_NCAUSE-1:0] : irq_mask_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl3_reg    <= FLD_CTRL3_RESET;
            status_reg   <= '0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            tmr_reg      <= '0;
        end else begin
            ctrl3_reg    <= ctrl3_next;
            status_reg   <= status_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            tmr_reg      <= tmr_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            // Ready in the first cycle of the access phase, data registered with it
            o_pready  <= i_psel && !i_penable;
            o_prdata  <= rdata;
            o_pslverr <= i_psel && !i_penable && !mapped;
        end
    end

    // Register-ready is delayed to the access cycle, so writes see pready
    // on the same edge they commit; the write strobe itself does not use pready
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_link_drop    <= 1'b0;
            o_eq_err_use   <= 1'b0;
            o_coef0_bypass <= 1'b0;
            o_pol_invert   <= 1'b0;
            o_pair_swap    <= 1'b0;
            o_port_mirror  <= 1'b0;
            o_irq          <= 1'b0;
        end else begin
            o_link_drop    <= drop_any;
            o_eq_err_use   <= !ctrl3_reg[FLD_B_EQ_ERR_BYP] &&
                              sync2_reg[NIN-1];
            o_coef0_bypass <= ctrl3_reg[FLD_B_COEF_BYP];
            o_pol_invert   <= ctrl3_reg[FLD_B_POL_SWAP];
            o_pair_swap    <= ctrl3_reg[FLD_B_PAIR_SWAP];
            o_port_mirror  <= ctrl3_reg[FLD_B_POL_SWAP] &&
                              ctrl3_reg[FLD_B_PAIR_SWAP];
            o_irq          <= |(irq_stat_next & irq_mask_next);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_descr_armed;
        ctrl3_reg[FLD_B_DESCR_DROP] && sync2_reg[FLD_C_DESCR];
    endsequence

    AST_EQ_BYPASS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ctrl3_reg[FLD_B_EQ_ERR_BYP] |=> !o_eq_err_use)
        else $error("equalizer error not ignored");
    AST_DESCR_DROP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_descr_armed |=> o_link_drop && status_reg[FLD_C_DESCR])
        else $error("descrambler loss did not drop link");
    AST_COEF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_coef0_bypass == $past(ctrl3_reg[FLD_B_COEF_BYP]))
        else $error("coefficient bypass mismatch");
    AST_POL: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(ctrl3_reg[FLD_B_POL_SWAP]) |=> o_pol_invert)
        else $error("polarity swap not applied");
    AST_PAIR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(ctrl3_reg[FLD_B_PAIR_SWAP]) |=> !o_pair_swap)
        else $error("pair swap not released");
    AST_MIRROR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_port_mirror |-> o_pol_invert && o_pair_swap)
        else $error("mirror without both swaps");
    AST_ENERGY: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !ctrl3_reg[FLD_B_ENERGY_DROP] && !ctrl3_reg[FLD_B_DESCR_DROP] &&
        !ctrl3_reg[FLD_B_RXER_DROP] && !ctrl3_reg[FLD_B_CODE_DROP] &&
        !ctrl3_reg[FLD_B_SNR_DROP] |=> !o_link_drop)
        else $error("drop with all causes disabled");
    AST_STATUS_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_link_drop |-> status_reg != '0)
        else $error("drop without latched cause");
    AST_ENERGY_DROP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ctrl3_reg[FLD_B_ENERGY_DROP] && sync2_reg[FLD_C_ENERGY]
        |=> o_link_drop)
        else $error("energy loss did not drop link");
endmodule

// ==== tb/fld_tb.sv ====
// Self-checking bench for the fast link-down control block.
// Assumes fld_pkg and fld_evt_if are compiled first; bench drives APB.
`timescale 1ns/1ps
module testbench;
    import fld_pkg::*;
    // ****************************************************
    // Signals
    // ****************************************************
    // Window must exceed twice the largest threshold, since
    // counted events need a low cycle between rising edges
    localparam int WCYC = 100;
    logic        i_clk, i_resetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:1]  ev;
    logic        descr, energy, eq_err, pready, pslverr, drop;
    logic        eq_use, coef, pol, pair, mirror, irq;
    int          miscompares, n_tests, cyc;
    fld_top #(.WINDOW_CYC(WCYC)) i_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_descr_loss(descr), .i_rx_err(ev[3]),
        .i_code_viol(ev[2]), .i_snr_cross(ev[1]),
        .i_energy_loss(energy), .i_eq_err(eq_err), .o_link_drop(drop),
        .o_eq_err_use(eq_use), .o_coef0_bypass(coef),
        .o_pol_invert(pol), .o_pair_swap(pair),
        .o_port_mirror(mirror), .o_irq(irq));
    // ****************************************************
    // Clock, timeout, reporting
    // ****************************************************
    always #2.5 i_clk = ~i_clk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 2200 cycles the tests take
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ****************************************************
    // APB master: holds the request until pready is sampled
    // ****************************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    // Counted events: one-cycle pulses, drop sampled every edge
    task automatic burst(input int c, input int n, output logic seen);
        seen = 1'b0;
        // A trip shows as a one-cycle pulse, so look at both edges
        repeat (n) begin
            @(posedge i_clk);
            seen = seen | (drop === 1'b1);
            ev[c] <= 1'b1;
            @(posedge i_clk);
            seen = seen | (drop === 1'b1);
            ev[c] <= 1'b0;
        end
        repeat (8) begin
            @(posedge i_clk);
            seen = seen | (drop === 1'b1);
        end
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(FLD_ADDR_CTRL3, r);
        chk32(r, 32'h0000_1000);
        @(posedge i_clk);
        eq_err <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk1(eq_use, 1'b0);
        wr(FLD_ADDR_CTRL3, 32'h0);
        repeat (6) @(posedge i_clk);
        chk1(eq_use, 1'b1);
        for (int v = 0; v < 4; v++) begin
            wr(FLD_ADDR_CTRL3, (v << 5) | ((v & 1) << 9));
            repeat (3) @(posedge i_clk);
            chk1(pair, v[0]);
            chk1(pol, v[1]);
            chk1(coef, v[0]);
            chk1(mirror, v == 3);
        end
        wr(FLD_ADDR_CTRL3, 32'hffff_ffff);
        rd(FLD_ADDR_CTRL3, r);
        chk32(r, {16'h0, FLD_CTRL3_WMASK});
        apb(1'b0, 12'h200, 32'h0, r, e);
        chk1(e, 1'b1);
        chk32(r, 32'h0);
        wr(FLD_ADDR_CTRL3, 32'h0);
        $display("test regs done");
    endtask
    // Level causes: drop follows the pin only while enabled
    task automatic t_level(input int b, input int c);
        logic [31:0] r;
        rd(FLD_ADDR_STATUS, r);
        wr(FLD_ADDR_CTRL3, 32'h401 & ~(32'h1 << b));
        @(posedge i_clk);
        if (c == FLD_C_DESCR) descr <= 1'b1;
        else energy <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk1(drop, 1'b0);
        wr(FLD_ADDR_CTRL3, 32'h401);
        repeat (8) @(posedge i_clk);
        chk1(drop, 1'b1);
        descr <= 1'b0;
        energy <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk1(drop, 1'b0);
        rd(FLD_ADDR_STATUS, r);
        chk32(r, 32'h1 << (c + FLD_STATUS_LSB));
        $display("test level cause %0d done", c);
    endtask
    task automatic t_irq();
        logic [31:0] r;
        rd(FLD_ADDR_IRQ_STAT, r);
        chk32(r, 32'h11);
        chk1(irq, 1'b0);
        wr(FLD_ADDR_IRQ_MASK, 32'h1f);
        repeat (3) @(posedge i_clk);
        chk1(irq, 1'b1);
        wr(FLD_ADDR_IRQ_STAT, 32'h01);
        rd(FLD_ADDR_IRQ_STAT, r);
        chk32(r, 32'h10);
        wr(FLD_ADDR_IRQ_MASK, 32'h01);
        repeat (3) @(posedge i_clk);
        chk1(irq, 1'b0);
        wr(FLD_ADDR_IRQ_STAT, 32'h10);
        wr(FLD_ADDR_IRQ_MASK, 32'h1f);
        $display("test irq done");
    endtask
    // Counted causes: threshold only within one window
    task automatic t_count(input int c, input int th);
        logic [31:0] r;
        logic        s;
        rd(FLD_ADDR_STATUS, r);
        wr(FLD_ADDR_CTRL3, 32'h0);
        burst(c, 60, s);
        chk1(s, 1'b0);
        wr(FLD_ADDR_CTRL3, 32'h1 << c);
        burst(c, th - 1, s);
        chk1(s, 1'b0);
        repeat (WCYC + 10) @(posedge i_clk);
        burst(c, th - 1, s);
        chk1(s, 1'b0);
        burst(c, 150, s);
        chk1(s, 1'b1);
        rd(FLD_ADDR_STATUS, r);
        chk32(r, 32'h1 << (c + FLD_STATUS_LSB));
        rd(FLD_ADDR_IRQ_STAT, r);
        chk32(r, 32'h1 << c);
        chk1(irq, 1'b1);
        wr(FLD_ADDR_IRQ_STAT, 32'h1f);
        repeat (3) @(posedge i_clk);
        chk1(irq, 1'b0);
        $display("test counted cause %0d done", c);
    endtask
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ev, descr, energy, eq_err} = '0;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_level(FLD_B_DESCR_DROP, FLD_C_DESCR);
        t_level(FLD_B_ENERGY_DROP, FLD_C_ENERGY);
        t_irq();
        t_count(FLD_C_RXER, FLD_RXER_THRESH);
        t_count(FLD_C_CODE, FLD_CODE_THRESH);
        t_count(FLD_C_SNR, FLD_SNR_THRESH);
        end_sim();
    end
endmodule
